// >>> tb.sv
// Self-checking bench for the timer mode and function control block
`timescale 1ns/1ps
module tb
  import tmf_pkg::*;
;
  logic pclk;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] ext_match_a = 3'h0, ext_match_b = 3'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, irq, quad_a, quad_b, err, seen;
  logic [4:0] output_pin_a, output_pin_a_oe;
  logic [1:0] output_pin_b, output_pin_b_oe;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] ofs [3] = '{OFS_MODE, OFS_FCTL, OFS_MOEN};
  logic [7:0] rstv [3] = '{MODE_RST, FCTL_RST, MOEN_RST};
  logic [7:0] rsvd [3] = '{MODE_RSVD, FCTL_RSVD, MOEN_RSVD};

  // ----------------------------------------
  // Clock, design and encoder
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  tmf_timer_mode dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby(standby), .quad_clock_in_a(quad_a), .quad_clock_in_b(quad_b),
    .ext_match_a(ext_match_a), .ext_match_b(ext_match_b), .output_pin_a(output_pin_a),
    .output_pin_a_oe(output_pin_a_oe), .output_pin_b(output_pin_b),
    .output_pin_b_oe(output_pin_b_oe), .irq(irq)
  );

  tmf_quad_enc enc_u (.quad_a(quad_a), .quad_b(quad_b), .pclk(pclk));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare one value; x or z never passes
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      bad_count++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask

  // Interrupt follows its cause a cycle late, so let two edges pass
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  // One-cycle compare match pulse, then time for the pin register
  task automatic mpulse(input bit isb, input int c);
    @(posedge pclk);
    if (isb)
      ext_match_b[c] <= 1'b1;
    else
      ext_match_a[c] <= 1'b1;
    @(posedge pclk);
    ext_match_a <= 3'h0;
    ext_match_b <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic sby();
    @(posedge pclk);
    standby <= 1'b1;
    repeat (3) @(posedge pclk);
    standby <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog: the tests need a few thousand cycles at most
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rd(ofs[i], {24'h0, rstv[i]}, "reset value");
      wr(ofs[i], 32'h0);
      rd(ofs[i], {24'h0, rsvd[i]}, "reserved bits");
      wr(ofs[i], {24'h0, rstv[i]});
    end
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b1, 8'h06, 32'hFF);
    chk("misaligned error", 32'h1, {31'h0, err});
    fin("registers");
    // Phase counting, then overflow flag conditions in both directions
    wr(OFS_MODE, 32'h40);
    wr(OFS_CTRL, 32'h01);
    repeat (40) @(posedge pclk);
    rd(OFS_CNT2, 32'h0, "count idle");
    enc_u.move(5, 1'b1, 0);
    rd(OFS_CNT2, 32'h5, "count up");
    enc_u.move(7, 1'b0, 4);
    rd(OFS_CNT2, 32'hFFFE, "count down");
    rd(OFS_IRQ_STAT, 32'h1, "underflow flag");
    wr(OFS_IRQ_EN, 32'h1);
    irqchk(1'b1);
    wr(OFS_IRQ_EN, 32'h0);
    irqchk(1'b0);
    wr(OFS_IRQ_CLR, 32'h1);
    rd(OFS_IRQ_STAT, 32'h0, "flag cleared");
    wr(OFS_MODE, 32'h60);
    enc_u.move(2, 1'b1, 0);
    rd(OFS_IRQ_STAT, 32'h1, "overflow flag");
    wr(OFS_IRQ_CLR, 32'h1);
    enc_u.move(1, 1'b0, 0);
    rd(OFS_CNT2, 32'hFFFF, "count wrap");
    rd(OFS_IRQ_STAT, 32'h0, "no underflow flag");
    wr(OFS_IRQ_EN, 32'h1);
    enc_u.move(1, 1'b1, 0);
    irqchk(1'b1);
    wr(OFS_IRQ_CLR, 32'h1);
    irqchk(1'b0);
    wr(OFS_CTRL, 32'h0);
    fin("phase");
    // PWM pins of channels 0 to 2 follow their matches
    wr(OFS_MODE, 32'h07);
    for (int c = 0; c < 3; c++)
    begin
      mpulse(1'b0, c);
      chk("pin set", 32'h1, {31'h0, output_pin_a[c]});
      mpulse(1'b1, c);
      chk("pin clear", 32'h0, {31'h0, output_pin_a[c]});
    end
    chk("pin A enable", 32'h07, {27'h0, output_pin_a_oe});
    // Leave pin 0 high so that standby has something to clear
    mpulse(1'b0, 0);
    wr(OFS_FCTL, 32'h0F);
    wr(OFS_MOEN, 32'h00);
    sby();
    chk("standby pins", 32'h0, {27'h0, output_pin_a});
    for (int i = 0; i < 3; i++)
      rd(ofs[i], {24'h0, rstv[i]}, "standby value");
    fin("pwm and standby");
    // Buffered general register reloads on its match, the other holds
    wr(OFS_GEN0, 32'h3);
    wr(OFS_GEN0 + 8'h04, 32'h7);
    wr(OFS_BUF0, 32'h10);
    wr(OFS_BUF0 + 8'h04, 32'h20);
    wr(OFS_FCTL, 32'h01);
    wr(OFS_CTRL, 32'h02);
    repeat (40) @(posedge pclk);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_GEN0, 32'h10, "buffered reload");
    rd(OFS_GEN0 + 8'h04, 32'h7, "unbuffered hold");
    fin("buffer");
    // Combination codes with PWM bits 3 and 4 left at zero
    sby();
    for (int k = 0; k < 4; k++)
      wr(OFS_GEN0 + 8'(4 * k), k[0] ? 32'h5 : 32'h2);
    for (int code = 3; code >= 0; code--)
    begin
      wr(OFS_CTRL, 32'h0);
      wr(OFS_FCTL, 32'(code << 4));
      wr(OFS_CTRL, 32'h0E);
      seen = 1'b0;
      repeat (60)
      begin
        @(posedge pclk);
        seen = seen | output_pin_a[3];
      end
      chk("combined pin A", 32'(code >> 1), {31'h0, seen});
      chk("pin B enable", (code >= 2) ? 32'h3 : 32'h0, {30'h0, output_pin_b_oe});
      if (code >= 2)
        chk("pin B level", {31'h0, output_pin_a[3] ^ ~code[0]}, {31'h0, output_pin_b[0]});
    end
    // Both sync bits: channel 3 restarts channel 4 before it reaches its own match A
    sby();
    wr(OFS_FCTL, 32'h30);
    wr(OFS_GEN0 + 8'h08, 32'h9);
    wr(OFS_CTRL, 32'h1E);
    seen = 1'b0;
    repeat (60)
    begin
      @(posedge pclk);
      seen = seen | output_pin_a[4];
    end
    chk("synced restart", 32'h0, {31'h0, seen});
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FCTL, 32'h30);
    wr(OFS_MOEN, 32'hFC);
    repeat (3) @(posedge pclk);
    chk("master enable gate", 32'h2, {30'h0, output_pin_b_oe});
    chk("pin A enable", 32'h10, {27'h0, output_pin_a_oe});
    fin("combined");
    summarize();
  end
endmodule  // tb

// >>> tmf_phase_counter.sv
// Channel 2 counter with quadrature (phase) counting and overflow event
`timescale 1ns/1ps
module tmf_phase_counter
  import tmf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby,
  input wire logic phase_mode,
  input wire logic flag_direction,
  input wire logic run,
  input wire logic tick,
  input wire logic quad_clock_in_a,
  input wire logic quad_clock_in_b,
  output logic [15:0] count,
  output logic ovf_event
);

  logic qa_q;
  logic qb_q;
  logic [15:0] cnt_q;
  logic ovf_q;
  logic ch_a;
  logic ch_b;
  logic qstep;
  logic up;
  logic step;
  logic dn;
  logic wrap_up;
  logic wrap_dn;

  // Any single edge of either input is a step; both at once is ignored
  assign ch_a = quad_clock_in_a ^ qa_q;
  assign ch_b = quad_clock_in_b ^ qb_q;
  assign qstep = ch_a ^ ch_b;
  // A leading B gives up, A trailing B gives down
  assign up = quad_clock_in_a ^ qb_q;
  // Phase mode overrides the internal tick as the count source
  assign step = run & (phase_mode ? qstep : tick);
  assign dn = phase_mode & ~up;
  assign wrap_up = step & ~dn & (cnt_q == 16'hFFFF);
  assign wrap_dn = step & dn & (cnt_q == 16'h0000);

  // Counter, input history and overflow pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qa_q <= 1'b0;
      qb_q <= 1'b0;
      cnt_q <= 16'h0000;
      ovf_q <= 1'b0;
    end
    else
    begin
      qa_q <= quad_clock_in_a;
      qb_q <= quad_clock_in_b;
      if (standby)
        cnt_q <= 16'h0000;
      else if (step)
        cnt_q <= dn ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      // Underflow only counts when the direction flag is zero
      ovf_q <= wrap_up | (wrap_dn & ~flag_direction);
    end
  end

  assign count = cnt_q;
  assign ovf_event = ovf_q;

endmodule // tmf_phase_counter

// >>> tmf_pkg.sv
// Constants shared by the timer mode and function control block
package tmf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_FCTL = 8'h04;
  localparam logic [7:0] OFS_MOEN = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_CNT2 = 8'h1C;
  localparam logic [7:0] OFS_CNT3 = 8'h20;
  localparam logic [7:0] OFS_CNT4 = 8'h24;
  localparam logic [7:0] OFS_GEN0 = 8'h28;
  localparam logic [7:0] OFS_BUF0 = 8'h38;

  // ----------------------------------------------------------------
  // Reset values and read-only-one masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h80;
  localparam logic [7:0] FCTL_RST = 8'hC0;
  localparam logic [7:0] MOEN_RST = 8'hFF;
  localparam logic [7:0] MODE_RSVD = 8'h80;
  localparam logic [7:0] FCTL_RSVD = 8'hC0;
  localparam logic [7:0] MOEN_RSVD = 8'hC0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] GEN_RST = 16'hFFFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_PHASE_BIT = 6;
  localparam int MODE_FLAG_DIRECTION_BIT = 5;
  localparam int FCTL_CMB_HI = 5;
  localparam int FCTL_CMB_LO = 4;
  localparam int CTRL_RUN2 = 0;
  localparam int CTRL_RUN3 = 1;
  localparam int CTRL_RUN4 = 2;
  localparam int CTRL_SYNC_CH3 = 3;
  localparam int CTRL_SYNC_CH4 = 4;
  localparam int IRQ_OVF2 = 0;
  localparam int IRQ_MATCH3 = 1;
  localparam int IRQ_MATCH4 = 2;
  localparam int IRQ_W = 3;

  // Combination field codes for channels 3 and 4
  typedef enum logic [1:0] {
    TMF_CMB_NORM0 = 2'b00,
    TMF_CMB_NORM1 = 2'b01,
    TMF_CMB_COMPL = 2'b10,
    TMF_CMB_RSYNC = 2'b11
  } tmf_cmb_t;

  // ----------------------------------------------------------------
  // Timing: internal count tick period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_NS = 400;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

endpackage

// >>> tmf_quad_enc.sv
// Quadrature encoder model that drives the two phase inputs of channel 2
`timescale 1ns/1ps
module tmf_quad_enc
#(
  parameter int GAP = 2
)
(
  output logic quad_a,
  output logic quad_b,
  input wire logic pclk
);
  logic [1:0] phase_q = 2'd0;

  // Both phases decode from one step counter, which keeps one driver per pin
  // Rest state 00 has both phases low
  assign quad_a = phase_q[1] ^ phase_q[0];
  assign quad_b = phase_q[1];

  // Walk n quarter steps; states 00,10,11,01 (A,B) mean A leads B
  // Only one phase changes per step, so no edge pair can be misread as a jump
  task automatic move(input int n, input bit up, input int slow);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      phase_q <= up ? phase_q + 2'd1 : phase_q - 2'd1;
      repeat (GAP + slow) @(posedge pclk);
    end
  endtask
endmodule  // tmf_quad_enc

// >>> tmf_timer_mode.sv
// Timer mode, function control and output master enable logic with APB slave
`timescale 1ns/1ps
module tmf_timer_mode
  import tmf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby,
  input wire logic quad_clock_in_a,
  input wire logic quad_clock_in_b,
  input wire logic [2:0] ext_match_a,
  input wire logic [2:0] ext_match_b,
  output logic [4:0] output_pin_a,
  output logic [4:0] output_pin_a_oe,
  output logic [1:0] output_pin_b,
  output logic [1:0] output_pin_b_oe,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Compare hit of a running counter against a general register
  function automatic logic cmp_hit(input logic [15:0] cnt, input logic [15:0] gen,
                                   input logic en);
    cmp_hit = en & (cnt == gen);
  endfunction

  // Apply the read-only-one mask to a written byte
  function automatic logic [7:0] keep_ones(input logic [7:0] wd, input logic [7:0] rsvd);
    keep_ones = wd | rsvd;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] mode_q;
  logic [7:0] fctl_q;
  logic [7:0] moen_q;
  logic [7:0] ctrl_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic irq_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [15:0] gen_q [4];
  logic [15:0] buf_q [4];
  logic [15:0] cnt34_q [2];
  logic [4:0] pin_a_q;
  logic [4:0] pin_a_oe_q;
  logic [1:0] pin_b_q;
  logic [1:0] pin_b_oe_q;
  logic [$clog2(TICK_CYCLES)-1:0] div_q;
  logic tick;
  logic access;
  logic wr_en;
  logic rd_en;
  logic sel_gen;
  logic sel_buf;
  logic [1:0] reg_idx;
  logic addr_ok;
  logic [31:0] rd_mux;
  tmf_cmb_t cmb;
  logic combo;
  logic rsync;
  logic [4:0] pwm_eff;
  logic [15:0] cnt2;
  logic ovf2;
  logic [3:0] hit;
  logic [4:0] set_a;
  logic [4:0] set_b;
  logic clr3;
  logic clr4;
  logic [1:0] run34;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr_w;

  // ----------------------------------------------------------------
  // Count tick divider
  // ----------------------------------------------------------------

  // One-cycle enable every TICK_CYCLES clocks drives the normal count rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= '0;
    else if (tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  assign tick = (div_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Answer comes one cycle into the access phase so read data is registered
  assign access = psel & penable;
  assign wr_en = access & pready_q & pwrite & addr_ok;
  assign rd_en = access & ~pready_q & ~pwrite;
  assign sel_gen = (paddr[7:4] == OFS_GEN0[7:4] && paddr[3:2] >= 2'b10) ||
                   (paddr[7:4] == 4'h3 && paddr[3:2] < 2'b10);
  assign sel_buf = (paddr[7:4] == OFS_BUF0[7:4] && paddr[3:2] >= 2'b10) ||
                   (paddr[7:4] == 4'h4 && paddr[3:2] < 2'b10);
  assign reg_idx = sel_gen ? 2'(paddr[5:2] - OFS_GEN0[5:2]) : 2'(paddr[5:2] - OFS_BUF0[5:2]);
  assign addr_ok = (paddr[1:0] == 2'b00) &&
                   (paddr <= OFS_CNT4 || sel_gen || sel_buf);

  // Read multiplexer; the clear register reads as zero
  assign rd_mux = (paddr == OFS_MODE) ? {24'h0, mode_q} :
                  (paddr == OFS_FCTL) ? {24'h0, fctl_q} :
                  (paddr == OFS_MOEN) ? {24'h0, moen_q} :
                  (paddr == OFS_CTRL) ? {24'h0, ctrl_q} :
                  (paddr == OFS_IRQ_STAT) ? {29'h0, stat_q} :
                  (paddr == OFS_IRQ_EN) ? {29'h0, irq_en_q} :
                  (paddr == OFS_CNT2) ? {16'h0, cnt2} :
                  (paddr == OFS_CNT3) ? {16'h0, cnt34_q[0]} :
                  (paddr == OFS_CNT4) ? {16'h0, cnt34_q[1]} :
                  sel_gen ? {16'h0, gen_q[reg_idx]} :
                  sel_buf ? {16'h0, buf_q[reg_idx]} : 32'h0;

  // Bus handshake and read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~addr_ok;
      if (rd_en)
        prdata_q <= addr_ok ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Mode, function control, master enable and run/sync registers
  // ----------------------------------------------------------------

  // Standby reloads the reset values of all but the interrupt enable, which keeps its value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= MODE_RST;
      fctl_q <= FCTL_RST;
      moen_q <= MOEN_RST;
      ctrl_q <= CTRL_RST;
      irq_en_q <= '0;
    end
    else if (standby)
    begin
      mode_q <= MODE_RST;
      fctl_q <= FCTL_RST;
      moen_q <= MOEN_RST;
      ctrl_q <= CTRL_RST;
    end
    else if (wr_en)
    begin
      if (paddr == OFS_MODE)
        mode_q <= keep_ones(pwdata[7:0], MODE_RSVD);
      if (paddr == OFS_FCTL)
        fctl_q <= keep_ones(pwdata[7:0], FCTL_RSVD);
      if (paddr == OFS_MOEN)
        moen_q <= keep_ones(pwdata[7:0], MOEN_RSVD);
      if (paddr == OFS_CTRL)
        ctrl_q <= {3'b000, pwdata[4:0]};
      if (paddr == OFS_IRQ_EN)
        irq_en_q <= pwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  assign cmb = tmf_cmb_t'(fctl_q[FCTL_CMB_HI:FCTL_CMB_LO]);
  assign combo = (cmb == TMF_CMB_COMPL) || (cmb == TMF_CMB_RSYNC);
  assign rsync = (cmb == TMF_CMB_RSYNC);
  // Combined modes take channels 3 and 4 away from the PWM bits
  assign pwm_eff = {mode_q[4:3] & {2{~combo}}, mode_q[2:0]};
  assign run34 = {ctrl_q[CTRL_RUN4], ctrl_q[CTRL_RUN3]};

  // ----------------------------------------------------------------
  // Channel 2 counter
  // ----------------------------------------------------------------
  tmf_phase_counter u_ch2
  (
    .pclk(pclk),
    .presetn(presetn),
    .standby(standby),
    .phase_mode(mode_q[MODE_PHASE_BIT]),
    .flag_direction(mode_q[MODE_FLAG_DIRECTION_BIT]),
    .run(ctrl_q[CTRL_RUN2]),
    .tick(tick),
    .quad_clock_in_a(quad_clock_in_a),
    .quad_clock_in_b(quad_clock_in_b),
    .count(cnt2),
    .ovf_event(ovf2)
  );

  // ----------------------------------------------------------------
  // Channels 3 and 4 counters, compare and buffer transfer
  // ----------------------------------------------------------------

  // Hit order 3A, 3B, 4A, 4B matches the buffer bit order
  assign hit[0] = cmp_hit(cnt34_q[0], gen_q[0], tick & run34[0]);
  assign hit[1] = cmp_hit(cnt34_q[0], gen_q[1], tick & run34[0]);
  assign hit[2] = cmp_hit(cnt34_q[1], gen_q[2], tick & run34[1]);
  assign hit[3] = cmp_hit(cnt34_q[1], gen_q[3], tick & run34[1]);

  // Reset-synchronized mode restarts on match A; sync bits tie the clears
  assign clr3 = (rsync & hit[0]) |
                (ctrl_q[CTRL_SYNC_CH3] & ctrl_q[CTRL_SYNC_CH4] & hit[2] & rsync);
  assign clr4 = (rsync & hit[2]) |
                (ctrl_q[CTRL_SYNC_CH3] & ctrl_q[CTRL_SYNC_CH4] & clr3);

  // Counters stop on software request; halting first is the caller's duty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt34_q[0] <= 16'h0000;
      cnt34_q[1] <= 16'h0000;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (standby || (c == 0 ? clr3 : clr4))
          cnt34_q[c] <= 16'h0000;
        else if (tick && run34[c])
          cnt34_q[c] <= cnt34_q[c] + 16'h0001;
      end
    end
  end

  // General and buffer registers; a buffered one reloads on its own match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        gen_q[i] <= GEN_RST;
        buf_q[i] <= GEN_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wr_en && sel_gen && reg_idx == 2'(i))
          gen_q[i] <= pwdata[15:0];
        else if (hit[i] && fctl_q[i])
          gen_q[i] <= buf_q[i];
        if (wr_en && sel_buf && reg_idx == 2'(i))
          buf_q[i] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------

  // Set on match A, clear on match B; A wins if both land together
  assign set_a = {hit[2], hit[0], ext_match_a};
  assign set_b = {hit[3], hit[1], ext_match_b};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_a_q <= 5'h00;
      pin_a_oe_q <= 5'h00;
      pin_b_q <= 2'b00;
      pin_b_oe_q <= 2'b00;
    end
    else
    begin
      for (int n = 0; n < 5; n++)
      begin
        if (!(pwm_eff[n] || (n >= 3 && combo)))
          pin_a_q[n] <= 1'b0;
        else if (set_a[n])
          pin_a_q[n] <= 1'b1;
        else if (set_b[n])
          pin_a_q[n] <= 1'b0;
      end
      pin_a_oe_q[2:0] <= pwm_eff[2:0];
      // Master enable gates channel 3/4 pins whatever the mode says
      pin_a_oe_q[3] <= (pwm_eff[3] | combo) & moen_q[0];
      pin_a_oe_q[4] <= (pwm_eff[4] | combo) & moen_q[2];
      pin_b_oe_q <= {combo & moen_q[3], combo & moen_q[1]};
      // Complementary mode drives pin B as the inverse of pin A
      pin_b_q <= (cmb == TMF_CMB_COMPL) ? ~pin_a_q[4:3] : pin_a_q[4:3];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  assign ev = {hit[2], hit[0], ovf2};
  assign clr_w = (wr_en && paddr == OFS_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

  // A new event in the clearing cycle survives: set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~clr_w) | ev;
      irq_q <= |(((stat_q & ~clr_w) | ev) & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // Output assignments
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign output_pin_a = pin_a_q;
  assign output_pin_a_oe = pin_a_oe_q;
  assign output_pin_b = pin_b_q;
  assign output_pin_b_oe = pin_b_oe_q;
  assign irq = irq_q;

endmodule // tmf_timer_mode

// >>> tmf_timer_mode_assertions.sv
// Checker for the APB handshake, reserved bits and pin behaviour of the mode block
`timescale 1ns/1ps
module tmf_timer_mode_assertions
  import tmf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic standby,
  input wire logic [2:0] ext_match_a,
  input wire logic [2:0] ext_match_b,
  input wire logic [4:0] output_pin_a,
  input wire logic [1:0] output_pin_b_oe
);
  // ----------------------------------------
  // Clocking and named steps
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Access phase opens, then exactly one wait state before the answer
  sequence s_access_start;
    psel && penable && !$past(penable);
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  // Reads that completed without refusal
  wire rd_ok = pready && !pslverr && !pwrite;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  a_ready_wait: assert property (s_access_start |-> s_one_wait)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_misalign_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_err_rdata_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");

  // ----------------------------------------
  // Reserved bits and pins
  // ----------------------------------------
  a_mode_rsvd: assert property (rd_ok && paddr == OFS_MODE |-> prdata[31:7] == 25'h1)
    else $error("mode register reserved bit wrong");
  a_fctl_rsvd: assert property (rd_ok && paddr == OFS_FCTL |-> prdata[31:6] == 26'h3)
    else $error("function control reserved bits wrong");
  a_moen_rsvd: assert property (rd_ok && paddr == OFS_MOEN |-> prdata[31:6] == 26'h3)
    else $error("master enable reserved bits wrong");
  // A lone match B leaves pin A low two edges later
  a_pin_clr_b: assert property (
    ((ext_match_b & ~ext_match_a) != 3'h0) ##1 (ext_match_a == 3'h0)
    |=> (output_pin_a[2:0] & $past(ext_match_b & ~ext_match_a, 2)) == 3'h0)
    else $error("pin A not cleared by match B");
  // Pin A only rises shortly after its own match A
  a_pin_set_a: assert property (
    (output_pin_a[2:0] & ~$past(output_pin_a[2:0]) & ~$past(ext_match_a)
      & ~$past(ext_match_a, 2)) == 3'h0)
    else $error("pin A rose without match A");
  // Standby reloads modes, so no PWM pin stays active
  a_standby_quiet: assert property (
    standby [*2] |=> output_pin_a == 5'h0 && output_pin_b_oe == 2'h0)
    else $error("pins active after standby");
endmodule  // tmf_timer_mode_assertions

bind tmf_timer_mode tmf_timer_mode_assertions chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
  .ext_match_a(ext_match_a), .ext_match_b(ext_match_b), .output_pin_a(output_pin_a),
  .output_pin_b_oe(output_pin_b_oe)
);
